// [design/prb_pkg.sv]
// package for the gain ramp, boost and bypass register bank
package prb_pkg;
   // register indexes (printed offsets are not multiples of four)
   localparam logic [7:0] PRB_IDX_RAMP   = 8'h27;
   localparam logic [7:0] PRB_IDX_BOOST  = 8'h28;
   localparam logic [7:0] PRB_IDX_CHARGE = 8'h29;
   localparam logic [7:0] PRB_IDX_ROUTE  = 8'h2A;
   localparam logic [7:0] PRB_IDX_LVL0   = 8'h2B;
   localparam logic [7:0] PRB_IDX_LVL1   = 8'h2C;
   localparam int         PRB_ADDR_W     = 10;
   // reset values
   localparam logic [7:0] PRB_RST_RAMP   = 8'h00;
   localparam logic [7:0] PRB_RST_BOOST  = 8'h00;
   localparam logic [7:0] PRB_RST_CHARGE = 8'h3F;
   localparam logic [7:0] PRB_RST_ROUTE  = 8'h00;
   localparam logic [7:0] PRB_RST_LVL    = 8'h00;
   // field positions and masks
   localparam int         PRB_RATE_LSB   = 4;
   localparam int         PRB_OUTG_LSB   = 4;
   localparam logic [7:0] PRB_MSK_RAMP   = 8'h3F;
   localparam logic [7:0] PRB_MSK_BOOST  = 8'h0F;
   localparam logic [7:0] PRB_MSK_CHARGE = 8'h3F;
   localparam logic [7:0] PRB_MSK_ROUTE  = 8'h03;
   localparam logic [7:0] PRB_MSK_LVL    = 8'hFF;
   localparam logic [1:0] PRB_RESP_OKAY  = 2'b00;
   localparam logic [1:0] PRB_RESP_SLVERR = 2'b10;
   // ramp timing at 50 MHz
   localparam int         PRB_CLK_HZ     = 50_000_000;
   localparam int         PRB_RAMP0_US   = 21500;
   localparam int         PRB_RAMP1_US   = 42500;
   localparam int         PRB_RAMP2_US   = 85000;
   // cycles per microsecond first, so the 85 ms product stays inside 32 bits
   localparam int         PRB_RAMP0_CYC  = (PRB_CLK_HZ / 1_000_000) * PRB_RAMP0_US;
   localparam int         PRB_RAMP1_CYC  = (PRB_CLK_HZ / 1_000_000) * PRB_RAMP1_US;
   localparam int         PRB_RAMP2_CYC  = (PRB_CLK_HZ / 1_000_000) * PRB_RAMP2_US;
   localparam int         PRB_CNT_W      = 23;

   typedef enum logic [1:0] {
      PRB_RATE_SHORT = 2'b00,
      PRB_RATE_MID   = 2'b01,
      PRB_RATE_LONG  = 2'b10
   } prb_rate_t;

   typedef enum logic [1:0] {
      PRB_ROUTE_NONE = 2'b00,
      PRB_ROUTE_CH0  = 2'b01,
      PRB_ROUTE_CH1  = 2'b10,
      PRB_ROUTE_BOTH = 2'b11
   } prb_route_t;

   typedef struct packed {
      logic [3:0] ramp_off;
      logic [1:0] ramp_rate;
      logic [3:0] extra_gain;
      logic [3:0] in_click_guard_off;
      logic [1:0] out_click_guard_off;
      logic [1:0] route;
      logic [7:0] bypass_level0;
      logic [7:0] bypass_level1;
   } prb_ctrl_t;
endpackage

// [design/prb_stage_ramp.sv]
// gain-change ramp timer for one input gain stage
`timescale 1ns/10ps
module prb_stage_ramp
   import prb_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       gain_change,
   input  wire logic       ramp_off,
   input  wire logic [1:0] ramp_rate,
   output logic            ramping
);
   logic [PRB_CNT_W-1:0] cnt_reg;
   logic [PRB_CNT_W-1:0] load_val;

   always_comb begin
      unique case (ramp_rate)
         PRB_RATE_MID:  load_val = PRB_CNT_W'(PRB_RAMP1_CYC);
         PRB_RATE_LONG: load_val = PRB_CNT_W'(PRB_RAMP2_CYC);
         // code 11 is undefined; take the shortest ramp
         default:       load_val = PRB_CNT_W'(PRB_RAMP0_CYC);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else if (gain_change) begin
         cnt_reg <= ramp_off ? '0 : load_val;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - PRB_CNT_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ramping <= 1'b0;
      end else begin
         ramping <= gain_change ? !ramp_off : (cnt_reg > PRB_CNT_W'(1));
      end
   end

   a_ramp_off_jump: assert property (@(posedge aclk) disable iff (!aresetn)
      gain_change && ramp_off |=> !ramping)
      else $error("ramp ran while disabled");
endmodule

// [design/prb_axil_slave.sv]
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/10ps
module prb_axil_slave
   import prb_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [PRB_ADDR_W-1:0] s_awaddr,
   input  wire logic                  s_awvalid,
   output logic                       s_awready,
   input  wire logic [31:0]           s_wdata,
   input  wire logic [3:0]            s_wstrb,
   input  wire logic                  s_wvalid,
   output logic                       s_wready,
   output logic [1:0]                 s_bresp,
   output logic                       s_bvalid,
   input  wire logic                  s_bready,
   input  wire logic [PRB_ADDR_W-1:0] s_araddr,
   input  wire logic                  s_arvalid,
   output logic                       s_arready,
   output logic [31:0]                s_rdata,
   output logic [1:0]                 s_rresp,
   output logic                       s_rvalid,
   input  wire logic                  s_rready,
   output logic                       wr_en,
   output logic [7:0]                 wr_idx,
   output logic [7:0]                 wr_data,
   input  wire logic                  wr_hit,
   output logic [7:0]                 rd_idx,
   input  wire logic [7:0]            rd_data,
   input  wire logic                  rd_hit
);
   logic aw_have_reg;
   logic w_have_reg;
   logic [7:0] aw_idx_reg;
   logic [7:0] w_data_reg;
   logic       w_strb0_reg;

   assign wr_idx    = aw_idx_reg;
   assign wr_data   = w_data_reg;
   // only byte lane 0 carries data; a write without it stores nothing
   assign wr_en     = aw_have_reg && w_have_reg && w_strb0_reg && wr_hit;
   assign rd_idx    = s_araddr[9:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_idx_reg  <= 8'h00;
         w_data_reg  <= 8'h00;
         w_strb0_reg <= 1'b0;
         s_bvalid    <= 1'b0;
         s_bresp     <= PRB_RESP_OKAY;
         // readies are flops: low from their own take until the response is taken
         s_awready   <= 1'b1;
         s_wready    <= 1'b1;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_have_reg <= 1'b1;
            aw_idx_reg  <= s_awaddr[9:2];
            s_awready   <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_have_reg  <= 1'b1;
            w_data_reg  <= s_wdata[7:0];
            w_strb0_reg <= s_wstrb[0];
            s_wready    <= 1'b0;
         end
         if (aw_have_reg && w_have_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            s_bvalid    <= 1'b1;
            s_bresp     <= wr_hit ? PRB_RESP_OKAY : PRB_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= PRB_RESP_OKAY;
         s_arready <= 1'b1;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_arready <= 1'b0;
         s_rdata  <= rd_hit ? {24'h00_0000, rd_data} : 32'h0000_0000;
         s_rresp  <= rd_hit ? PRB_RESP_OKAY : PRB_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end
endmodule

// [design/prb_regs.sv]
// gain ramp, boost, click guard and adc-to-dac bypass register bank
// Summary of operation
// - a set ramp-off bit makes that stage change gain at once, ignoring rate
// - ramp-rate field bits 5:4 gives 21.5 ms, 42.5 ms or 85 ms ramps
// - four ramp-off bits, bit n for stage n, 1 disables, reset 0
// - four boost bits add 10 dB on top of each stage base gain
// - output click-guard disable bits at 5 and 4, 1 disables, reset 1
// - input click-guard disable bits at 3:0, bit n stage n, reset 1
// - two-bit route: none, adc0 to dac0, adc1 to dac1, or both
// - bypassed channel 0 takes its dac volume from level register 0
// - bypassed channel 1 takes its dac volume from level register 1
`timescale 1ns/10ps
module prb_regs
   import prb_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [PRB_ADDR_W-1:0] s_awaddr,
   input  wire logic                  s_awvalid,
   output logic                       s_awready,
   input  wire logic [31:0]           s_wdata,
   input  wire logic [3:0]            s_wstrb,
   input  wire logic                  s_wvalid,
   output logic                       s_wready,
   output logic [1:0]                 s_bresp,
   output logic                       s_bvalid,
   input  wire logic                  s_bready,
   input  wire logic [PRB_ADDR_W-1:0] s_araddr,
   input  wire logic                  s_arvalid,
   output logic                       s_arready,
   output logic [31:0]                s_rdata,
   output logic [1:0]                 s_rresp,
   output logic                       s_rvalid,
   input  wire logic                  s_rready,
   input  wire logic [3:0]            base_gain_change,
   input  wire logic [7:0]            dac_volume0,
   input  wire logic [7:0]            dac_volume1,
   output prb_ctrl_t                  ctrl,
   output logic [3:0]                 stage_ramping,
   output logic [3:0]                 boost_10db,
   output logic [1:0]                 adc_to_dac,
   output logic [7:0]                 dac_vol_used0,
   output logic [7:0]                 dac_vol_used1
);
   logic [7:0] ramp_reg;
   logic [7:0] boost_reg;
   logic [7:0] charge_reg;
   logic [7:0] route_reg;
   logic [7:0] lvl0_reg;
   logic [7:0] lvl1_reg;
   logic       wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic       wr_hit;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;
   logic       rd_hit;
   logic [3:0] ramping_w;
   logic [3:0] gain_change_w;

   prb_axil_slave u_bus (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_en     (wr_en),
      .wr_idx    (wr_idx),
      .wr_data   (wr_data),
      .wr_hit    (wr_hit),
      .rd_idx    (rd_idx),
      .rd_data   (rd_data),
      .rd_hit    (rd_hit)
   );

   function automatic logic idx_hit(input logic [7:0] idx);
      idx_hit = (idx >= PRB_IDX_RAMP) && (idx <= PRB_IDX_LVL1);
   endfunction

   assign wr_hit = idx_hit(wr_idx);
   assign rd_hit = idx_hit(rd_idx);

   // reserved bits are not stored, so they read back as zero
   always_comb begin
      unique case (rd_idx)
         PRB_IDX_RAMP:   rd_data = ramp_reg;
         PRB_IDX_BOOST:  rd_data = boost_reg;
         PRB_IDX_CHARGE: rd_data = charge_reg;
         PRB_IDX_ROUTE:  rd_data = route_reg;
         PRB_IDX_LVL0:   rd_data = lvl0_reg;
         PRB_IDX_LVL1:   rd_data = lvl1_reg;
         default:        rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ramp_reg <= PRB_RST_RAMP;
      end else if (wr_en && wr_idx == PRB_IDX_RAMP) begin
         ramp_reg <= wr_data & PRB_MSK_RAMP;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boost_reg <= PRB_RST_BOOST;
      end else if (wr_en && wr_idx == PRB_IDX_BOOST) begin
         boost_reg <= wr_data & PRB_MSK_BOOST;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         charge_reg <= PRB_RST_CHARGE;
      end else if (wr_en && wr_idx == PRB_IDX_CHARGE) begin
         charge_reg <= wr_data & PRB_MSK_CHARGE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         route_reg <= PRB_RST_ROUTE;
      end else if (wr_en && wr_idx == PRB_IDX_ROUTE) begin
         route_reg <= wr_data & PRB_MSK_ROUTE;
      end
   end

   // each level register has its own write decode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl0_reg <= PRB_RST_LVL;
      end else if (wr_en && wr_idx == PRB_IDX_LVL0) begin
         lvl0_reg <= wr_data & PRB_MSK_LVL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl1_reg <= PRB_RST_LVL;
      end else if (wr_en && wr_idx == PRB_IDX_LVL1) begin
         lvl1_reg <= wr_data & PRB_MSK_LVL;
      end
   end

   // a rate change alone does not restart a ramp in progress
   assign gain_change_w = base_gain_change;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_stage
         prb_stage_ramp u_ramp (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .gain_change (gain_change_w[g]),
            .ramp_off    (ramp_reg[g]),
            .ramp_rate   (ramp_reg[PRB_RATE_LSB +: 2]),
            .ramping     (ramping_w[g])
         );
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= '0;
      end else begin
         ctrl.ramp_off            <= ramp_reg[3:0];
         ctrl.ramp_rate           <= ramp_reg[PRB_RATE_LSB +: 2];
         ctrl.extra_gain          <= boost_reg[3:0];
         ctrl.in_click_guard_off  <= charge_reg[3:0];
         ctrl.out_click_guard_off <= charge_reg[PRB_OUTG_LSB +: 2];
         ctrl.route               <= route_reg[1:0];
         ctrl.bypass_level0       <= lvl0_reg;
         ctrl.bypass_level1       <= lvl1_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_ramping <= 4'h0;
      end else begin
         stage_ramping <= ramping_w;
      end
   end

   // a flag to the analog stage; the 10 dB step itself is made there
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boost_10db <= 4'h0;
      end else begin
         boost_10db <= boost_reg[3:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adc_to_dac <= 2'b00;
      end else begin
         adc_to_dac <= route_reg[1:0];
      end
   end

   // a bypassed channel ignores its normal volume until its route bit clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_vol_used0 <= 8'h00;
      end else begin
         dac_vol_used0 <= route_reg[0] ? lvl0_reg : dac_volume0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_vol_used1 <= 8'h00;
      end else begin
         dac_vol_used1 <= route_reg[1] ? lvl1_reg : dac_volume1;
      end
   end

   a_vol_bypass0: assert property (@(posedge aclk) disable iff (!aresetn)
      route_reg[0] && $stable(route_reg) && $stable(lvl0_reg) |=> dac_vol_used0 == $past(lvl0_reg))
      else $error("channel 0 bypass level not applied");
   a_vol_bypass1: assert property (@(posedge aclk) disable iff (!aresetn)
      route_reg[1] |=> dac_vol_used1 == $past(lvl1_reg))
      else $error("channel 1 bypass level not applied");
   a_vol_normal0: assert property (@(posedge aclk) disable iff (!aresetn)
      !route_reg[0] |=> dac_vol_used0 == $past(dac_volume0))
      else $error("channel 0 normal volume lost");
   a_vol_normal1: assert property (@(posedge aclk) disable iff (!aresetn)
      !route_reg[1] |=> dac_vol_used1 == $past(dac_volume1))
      else $error("channel 1 normal volume lost");
   a_route_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_ROUTE |=> ##1 adc_to_dac == $past(wr_data[1:0], 2))
      else $error("route write not reflected");
   a_boost_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_BOOST |=> ##1 boost_10db == $past(wr_data[3:0], 2))
      else $error("boost write not reflected");
   // field writes reach the control word two edges after the write strobe
   a_boost_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_BOOST |=> ##1 ctrl.extra_gain == $past(wr_data[3:0], 2))
      else $error("boost field not reflected");
   a_rate_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_RAMP |=> ##1 ctrl.ramp_rate == $past(wr_data[5:4], 2))
      else $error("ramp rate write not reflected");
   a_off_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_RAMP |=> ##1 ctrl.ramp_off == $past(wr_data[3:0], 2))
      else $error("ramp off write not reflected");
   a_in_guard_wr: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_CHARGE |=> ##1 ctrl.in_click_guard_off == $past(wr_data[3:0], 2))
      else $error("input guard write not reflected");
   a_out_guard_wr: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_CHARGE |=> ##1 ctrl.out_click_guard_off == $past(wr_data[5:4], 2))
      else $error("output guard write not reflected");
   a_level0_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_LVL0 |=> ##1 ctrl.bypass_level0 == $past(wr_data, 2))
      else $error("level 0 write not reflected");
   a_level1_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_idx == PRB_IDX_LVL1 |=> ##1 ctrl.bypass_level1 == $past(wr_data, 2))
      else $error("level 1 write not reflected");
   a_guard_reset: assert property (@(posedge aclk)
      !aresetn |=> charge_reg == 8'h3F && ramp_reg == 8'h00)
      else $error("reset values wrong");
   a_guard_out: assert property (@(posedge aclk) disable iff (!aresetn)
      $stable(charge_reg) |=> ctrl.out_click_guard_off == $past(charge_reg[5:4])
      && ctrl.in_click_guard_off == $past(charge_reg[3:0]))
      else $error("click guard bits not routed");
   a_ramp_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[0] && ramp_reg[0] |=> ##1 !stage_ramping[0])
      else $error("stage 0 ramped while disabled");
   a_ramp_runs: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[0] && !ramp_reg[0] |=> ##1 stage_ramping[0][*8])
      else $error("stage 0 ramp too short");
   // stages 1 to 3 share the stage 0 logic; each must follow its own bit
   a_ramp_off1: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[1] && ramp_reg[1] |=> ##1 !stage_ramping[1])
      else $error("stage 1 ramped while disabled");
   a_ramp_off2: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[2] && ramp_reg[2] |=> ##1 !stage_ramping[2])
      else $error("stage 2 ramped while disabled");
   a_ramp_off3: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[3] && ramp_reg[3] |=> ##1 !stage_ramping[3])
      else $error("stage 3 ramped while disabled");
   a_ramp_run1: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[1] && !ramp_reg[1] |=> ##1 stage_ramping[1])
      else $error("stage 1 ramp missing");
   a_ramp_run3: assert property (@(posedge aclk) disable iff (!aresetn)
      base_gain_change[3] && !ramp_reg[3] |=> ##1 stage_ramping[3])
      else $error("stage 3 ramp missing");
endmodule

// [tb/prb_regs_tb_top.sv]
// self-checking testbench for the gain ramp, boost and bypass register bank
`timescale 1ns/10ps
module prb_regs_tb_top
   import prb_pkg::*;
;
   logic                  aclk;
   logic                  aresetn;
   logic [PRB_ADDR_W-1:0] s_awaddr;
   logic                  s_awvalid;
   logic                  s_awready;
   logic [31:0]           s_wdata;
   logic [3:0]            s_wstrb;
   logic                  s_wvalid;
   logic                  s_wready;
   logic [1:0]            s_bresp;
   logic                  s_bvalid;
   logic                  s_bready;
   logic [PRB_ADDR_W-1:0] s_araddr;
   logic                  s_arvalid;
   logic                  s_arready;
   logic [31:0]           s_rdata;
   logic [1:0]            s_rresp;
   logic                  s_rvalid;
   logic                  s_rready;
   logic [3:0]            base_gain_change;
   logic [7:0]            dac_volume0;
   logic [7:0]            dac_volume1;
   prb_ctrl_t             ctrl;
   logic [3:0]            stage_ramping;
   logic [3:0]            boost_10db;
   logic [1:0]            adc_to_dac;
   logic [7:0]            dac_vol_used0;
   logic [7:0]            dac_vol_used1;
   int                    errors;
   int                    check_count;

   prb_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .base_gain_change(base_gain_change), .dac_volume0(dac_volume0), .dac_volume1(dac_volume1), .ctrl(ctrl),
      .stage_ramping(stage_ramping), .boost_10db(boost_10db), .adc_to_dac(adc_to_dac),
      .dac_vol_used0(dac_vol_used0), .dac_vol_used1(dac_vol_used1));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // every bus wait is bounded so a dead handshake ends the run instead of hanging it
   task automatic step(inout int n);
      n++;
      if (n > 100) begin
         errors++;
         $display("FAIL bus wait expected answer seen none");
         tally_and_finish();
      end
   endtask

   task automatic axi_wr(input logic [7:0] idx, input logic [31:0] data, input logic [3:0] strb,
                         output logic [1:0] resp);
      int   n;
      logic aw_done;
      logic w_done;
      logic got;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      got = 1'b0;
      @(posedge aclk);
      s_awaddr  <= {idx, 2'b00};
      s_awvalid <= 1'b1;
      s_wdata   <= data;
      s_wstrb   <= strb;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      // readies are looked at half a cycle early so they are settled at the taking edge
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         aw_done = aw_done | s_awready;
         w_done = w_done | s_wready;
         @(posedge aclk);
         if (aw_done) s_awvalid <= 1'b0;
         if (w_done) s_wvalid <= 1'b0;
         step(n);
      end
      while (!got) begin
         @(negedge aclk);
         got = s_bvalid;
         resp = s_bresp;
         @(posedge aclk);
         if (got) s_bready <= 1'b0;
         step(n);
      end
   endtask

   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
      int   n;
      logic hit;
      n = 0;
      hit = 1'b0;
      @(posedge aclk);
      s_araddr  <= {idx, 2'b00};
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      while (!hit) begin
         @(negedge aclk);
         hit = s_arready;
         @(posedge aclk);
         if (hit) s_arvalid <= 1'b0;
         step(n);
      end
      hit = 1'b0;
      while (!hit) begin
         @(negedge aclk);
         hit = s_rvalid;
         data = s_rdata;
         resp = s_rresp;
         @(posedge aclk);
         if (hit) s_rready <= 1'b0;
         step(n);
      end
   endtask

   task automatic wr_ok(input logic [7:0] idx, input logic [31:0] data);
      logic [1:0] r;
      axi_wr(idx, data, 4'hF, r);
      chk("write resp", {30'h0000_0000, PRB_RESP_OKAY}, {30'h0000_0000, r});
      @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] eresp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(idx, d, r);
      chk("read data", {24'h00_0000, exp}, d);
      chk("read resp", {30'h0000_0000, eresp}, {30'h0000_0000, r});
   endtask

   task automatic t_reset_values;
      rd_chk(PRB_IDX_RAMP, PRB_RST_RAMP, PRB_RESP_OKAY);
      rd_chk(PRB_IDX_BOOST, PRB_RST_BOOST, PRB_RESP_OKAY);
      rd_chk(PRB_IDX_CHARGE, PRB_RST_CHARGE, PRB_RESP_OKAY);
      rd_chk(PRB_IDX_ROUTE, PRB_RST_ROUTE, PRB_RESP_OKAY);
      rd_chk(PRB_IDX_LVL0, PRB_RST_LVL, PRB_RESP_OKAY);
      rd_chk(PRB_IDX_LVL1, PRB_RST_LVL, PRB_RESP_OKAY);
      chk("out guard", 32'h0000_0003, {30'h0000_0000, ctrl.out_click_guard_off});
      chk("in guard", 32'h0000_000F, {28'h000_0000, ctrl.in_click_guard_off});
   endtask

   task automatic t_access;
      logic [7:0] idx [6];
      logic [7:0] msk [6];
      logic [1:0] r;
      idx = '{PRB_IDX_RAMP, PRB_IDX_BOOST, PRB_IDX_CHARGE, PRB_IDX_ROUTE, PRB_IDX_LVL0, PRB_IDX_LVL1};
      msk = '{8'h3F, 8'h0F, 8'h3F, 8'h03, 8'hFF, 8'hFF};
      for (int i = 0; i < 6; i++) begin
         wr_ok(idx[i], {24'h00_0000, msk[i]});
         rd_chk(idx[i], msk[i], PRB_RESP_OKAY);
         wr_ok(idx[i], 32'h0000_0000);
         rd_chk(idx[i], 8'h00, PRB_RESP_OKAY);
      end
      // a cleared byte strobe must leave the register untouched
      axi_wr(PRB_IDX_LVL0, 32'h0000_0077, 4'h0, r);
      rd_chk(PRB_IDX_LVL0, 8'h00, PRB_RESP_OKAY);
      axi_wr(8'h2D, 32'h0000_00FF, 4'hF, r);
      chk("unmapped write resp", {30'h0000_0000, PRB_RESP_SLVERR}, {30'h0000_0000, r});
      rd_chk(8'h26, 8'h00, PRB_RESP_SLVERR);
   endtask

   task automatic pulse_all(input logic [3:0] exp);
      @(posedge aclk);
      base_gain_change <= 4'hF;
      @(posedge aclk);
      base_gain_change <= 4'h0;
      // the stage timer answers one edge after the pulse and the output one edge later
      @(posedge aclk);
      @(negedge aclk);
      chk("ramp start", {28'h000_0000, exp}, {28'h000_0000, stage_ramping});
      repeat (100) @(posedge aclk);
      @(negedge aclk);
      chk("ramp held", {28'h000_0000, exp}, {28'h000_0000, stage_ramping});
   endtask

   task automatic t_ramp;
      for (int c = 0; c < 3; c++) begin
         wr_ok(PRB_IDX_RAMP, {26'h000_0000, c[1:0], 4'hF});
         chk("ramp rate", c, {30'h0000_0000, ctrl.ramp_rate});
         chk("ramp off", 32'h0000_000F, {28'h000_0000, ctrl.ramp_off});
      end
      pulse_all(4'h0);
      wr_ok(PRB_IDX_RAMP, 32'h0000_0024);
      pulse_all(4'hB);
   endtask

   task automatic t_boost_guard;
      wr_ok(PRB_IDX_BOOST, 32'h0000_0009);
      chk("boost", 32'h0000_0009, {28'h000_0000, boost_10db});
      chk("boost ctrl", 32'h0000_0009, {28'h000_0000, ctrl.extra_gain});
      wr_ok(PRB_IDX_CHARGE, 32'h0000_0026);
      chk("out guard", 32'h0000_0002, {30'h0000_0000, ctrl.out_click_guard_off});
      chk("in guard", 32'h0000_0006, {28'h000_0000, ctrl.in_click_guard_off});
   endtask

   task automatic t_route;
      wr_ok(PRB_IDX_LVL0, 32'h0000_0011);
      wr_ok(PRB_IDX_LVL1, 32'h0000_00EE);
      for (int c = 0; c < 4; c++) begin
         wr_ok(PRB_IDX_ROUTE, c);
         chk("route", c, {30'h0000_0000, adc_to_dac});
         chk("route ctrl", c, {30'h0000_0000, ctrl.route});
         chk("vol0", c[0] ? 32'h0000_0011 : 32'h0000_005A, {24'h00_0000, dac_vol_used0});
         chk("vol1", c[1] ? 32'h0000_00EE : 32'h0000_00C3, {24'h00_0000, dac_vol_used1});
      end
      chk("level0", 32'h0000_0011, {24'h00_0000, ctrl.bypass_level0});
      chk("level1", 32'h0000_00EE, {24'h00_0000, ctrl.bypass_level1});
   endtask

   initial begin
      errors = 0;
      check_count = 0;
      aresetn = 1'b0;
      s_awaddr = '0;
      s_awvalid = 1'b0;
      s_wdata = 32'h0000_0000;
      s_wstrb = 4'h0;
      s_wvalid = 1'b0;
      s_bready = 1'b0;
      s_araddr = '0;
      s_arvalid = 1'b0;
      s_rready = 1'b0;
      base_gain_change = 4'h0;
      dac_volume0 = 8'h5A;
      dac_volume1 = 8'hC3;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      t_reset_values();
      t_access();
      t_ramp();
      t_boost_guard();
      t_route();
      tally_and_finish();
   end
endmodule
